// ### hdl/gp8_pkg.sv
/*
  Package for the eight-bit general-purpose port with analog sharing:
  register offsets, field positions, reset values and bus codes.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package gp8_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PORT_W = 8;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_OUTPUT_LATCH  = 8'h00; // normal read view
  localparam logic [7:0] OFS_DIRECTION     = 8'h04;
  localparam logic [7:0] OFS_PULLUP_ENABLE = 8'h08;
  localparam logic [7:0] OFS_ANALOG_DIS    = 8'h0c;
  localparam logic [7:0] OFS_CONTROL       = 8'h10;
  localparam logic [7:0] OFS_LATCH_RMW     = 8'h14; // latch read view
  localparam logic [7:0] OFS_PIN_STATUS    = 8'h18; // raw synced pins

  // ************************************************************
  // control register fields
  // ************************************************************
  localparam int unsigned CTL_STANDBY_PIN_STATE_BIT = 0;
  localparam int unsigned CTL_CMP_INPUT_DIS_BIT     = 1;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_OUTPUT_LATCH  = 8'h00;
  localparam logic [7:0] RST_DIRECTION     = 8'h00;
  localparam logic [7:0] RST_PULLUP_ENABLE = 8'h00;
  localparam logic [7:0] RST_ANALOG_DIS    = 8'h00;
  localparam logic       RST_STANDBY_PIN   = 1'b0;
  localparam logic       RST_CMP_INPUT_DIS = 1'b0;

  // ************************************************************
  // bus response codes
  // ************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // write channel states
  // ************************************************************
  typedef enum logic [1:0] {
    GP8_W_IDLE = 2'b01,
    GP8_W_RESP = 2'b10
  } gp8_wstate_type;

endpackage

// ### hdl/gp8_port.sv
/*
  Eight-bit general-purpose I/O port whose pins are shared with
  external interrupt, analog, comparator and peripheral functions.
  Assumes one 100 MHz clock, pins and peripheral signals synchronous
  or slow, and an AXI4-Lite master with at most one write and one
  read outstanding.
*/
`timescale 1ns/1ps
`default_nettype none

module gp8_port
  import gp8_pkg::*;
(
  input  wire logic              I_CLK,
  input  wire logic              I_RSTN,
  input  wire logic [ADDR_W-1:0] I_AWADDR,
  input  wire logic              I_AWVALID,
  output var  logic              O_AWREADY,
  input  wire logic [DATA_W-1:0] I_WDATA,
  input  wire logic [3:0]        I_WSTRB,
  input  wire logic              I_WVALID,
  output var  logic              O_WREADY,
  output var  logic [1:0]        O_BRESP,
  output var  logic              O_BVALID,
  input  wire logic              I_BREADY,
  input  wire logic [ADDR_W-1:0] I_ARADDR,
  input  wire logic              I_ARVALID,
  output var  logic              O_ARREADY,
  output var  logic [DATA_W-1:0] O_RDATA,
  output var  logic [1:0]        O_RRESP,
  output var  logic              O_RVALID,
  input  wire logic              I_RREADY,
  input  wire logic [PORT_W-1:0] I_PIN_IN,
  output var  logic [PORT_W-1:0] O_PIN_OUT,
  output var  logic [PORT_W-1:0] O_PIN_OE,
  output var  logic [PORT_W-1:0] O_PULLUP_ON,
  input  wire logic [PORT_W-1:0] I_PERIPH_OE,
  input  wire logic [PORT_W-1:0] I_PERIPH_OUT,
  input  wire logic              I_STANDBY,
  input  wire logic [PORT_W-1:0] I_EXT_IRQ_EN,
  output var  logic [PORT_W-1:0] O_EXT_IRQ_LEVEL,
  output var  logic [PORT_W-1:0] O_PORT_IN,
  output var  logic [1:0]        O_CMP_IN_EN
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [PORT_W-1:0] latch;
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] pull;
    logic [PORT_W-1:0] adis;
    logic              standby_pin_state;
    logic              cid;
    logic [PORT_W-1:0] sync1;
    logic [PORT_W-1:0] sync2;
    gp8_wstate_type    wst;
    logic              aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_full;
    logic [PORT_W-1:0] w_data;
    logic              w_lane0;
    logic              awready;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              arready;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic [PORT_W-1:0] pin_out;
    logic [PORT_W-1:0] pin_oe;
    logic [PORT_W-1:0] pull_on;
    logic [PORT_W-1:0] irq_lvl;
    logic [PORT_W-1:0] port_in;
    logic [1:0]        cmp_en;
  } gp8_state_type;

  gp8_state_type st_r;
  gp8_state_type st_nxt;

  logic [PORT_W-1:0] blk;
  logic [PORT_W-1:0] pin_view;
  logic [PORT_W-1:0] norm_view;
  logic [PORT_W-1:0] oe_c;
  logic [PORT_W-1:0] out_c;
  logic              float_all;

  // ************************************************************
  // per-pin datapath
  // ************************************************************
  // standby float and input blocking, read views and drive values
  assign float_all = I_STANDBY & st_r.standby_pin_state;
  assign blk       = {PORT_W{float_all}} & ~I_EXT_IRQ_EN;
  assign pin_view  = st_r.sync2 & st_r.adis & ~blk;

  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_pin
      // output pins read the latch unless a peripheral drives them
      assign norm_view[gi] = (st_r.dir[gi] & ~I_PERIPH_OE[gi]) ?
                             st_r.latch[gi] : pin_view[gi];
      // peripheral output wins, otherwise the latch
      assign out_c[gi] = I_PERIPH_OE[gi] ? I_PERIPH_OUT[gi]
                                         : st_r.latch[gi];
      assign oe_c[gi]  = ~float_all &
                         (st_r.dir[gi] | I_PERIPH_OE[gi]);
    end
  endgenerate

  // ************************************************************
  // next-state logic
  // ************************************************************
  // bus slave, register file and pin stage
  always_comb begin
    logic            do_wr;
    logic [7:0]      waddr;
    logic [7:0]      raddr;
    st_nxt = st_r;
    do_wr  = 1'b0;
    waddr  = st_r.aw_addr;
    raddr  = I_ARADDR;

    // two-stage pin synchroniser
    st_nxt.sync1 = I_PIN_IN;
    st_nxt.sync2 = st_r.sync1;

    // write address and data are taken in either order
    if (I_AWVALID && st_r.awready) begin
      st_nxt.aw_full = 1'b1;
      st_nxt.aw_addr = I_AWADDR;
    end
    if (I_WVALID && st_r.wready) begin
      st_nxt.w_full  = 1'b1;
      st_nxt.w_data  = I_WDATA[PORT_W-1:0];
      st_nxt.w_lane0 = I_WSTRB[0];
    end

    case (st_r.wst)
      GP8_W_IDLE: begin
        if (st_r.aw_full && st_r.w_full) begin
          do_wr         = st_r.w_lane0;
          st_nxt.aw_full = 1'b0;
          st_nxt.w_full  = 1'b0;
          st_nxt.bvalid  = 1'b1;
          st_nxt.wst     = GP8_W_RESP;
          case (waddr)
            OFS_OUTPUT_LATCH, OFS_DIRECTION, OFS_PULLUP_ENABLE,
            OFS_ANALOG_DIS, OFS_CONTROL, OFS_LATCH_RMW,
            OFS_PIN_STATUS: st_nxt.bresp = RESP_OKAY;
            default:        st_nxt.bresp = RESP_SLVERR;
          endcase
        end
      end
      GP8_W_RESP: begin
        if (I_BREADY) begin
          st_nxt.bvalid = 1'b0;
          st_nxt.wst    = GP8_W_IDLE;
        end
      end
      default: begin
        st_nxt.wst    = GP8_W_IDLE;
        st_nxt.bvalid = 1'b0;
      end
    endcase
    st_nxt.awready = ~st_nxt.aw_full & (st_nxt.wst == GP8_W_IDLE);
    st_nxt.wready  = ~st_nxt.w_full & (st_nxt.wst == GP8_W_IDLE);

    // register writes; the latch is written whatever the direction
    if (do_wr) begin
      case (waddr)
        OFS_OUTPUT_LATCH,
        OFS_LATCH_RMW:     st_nxt.latch = st_r.w_data;
        OFS_DIRECTION:     st_nxt.dir   = st_r.w_data;
        OFS_PULLUP_ENABLE: st_nxt.pull  = st_r.w_data;
        OFS_ANALOG_DIS:    st_nxt.adis  = st_r.w_data;
        OFS_CONTROL: begin
          st_nxt.standby_pin_state = st_r.w_data[CTL_STANDBY_PIN_STATE_BIT];
          st_nxt.cid = st_r.w_data[CTL_CMP_INPUT_DIS_BIT];
        end
        default: st_nxt.latch = st_r.latch;
      endcase
    end

    // read channel, one read at a time
    if (st_r.rvalid && I_RREADY) begin
      st_nxt.rvalid  = 1'b0;
      st_nxt.arready = 1'b1;
    end
    if (I_ARVALID && st_r.arready) begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid  = 1'b1;
      st_nxt.rresp   = RESP_OKAY;
      st_nxt.rdata   = '0;
      case (raddr)
        OFS_OUTPUT_LATCH:  st_nxt.rdata[7:0] = norm_view;
        OFS_LATCH_RMW:     st_nxt.rdata[7:0] = st_r.latch;
        OFS_DIRECTION:     st_nxt.rdata[7:0] = st_r.dir;
        OFS_PULLUP_ENABLE: st_nxt.rdata[7:0] = st_r.pull;
        OFS_ANALOG_DIS:    st_nxt.rdata[7:0] = st_r.adis;
        OFS_PIN_STATUS:    st_nxt.rdata[7:0] = st_r.sync2;
        OFS_CONTROL: begin
          st_nxt.rdata[CTL_STANDBY_PIN_STATE_BIT] = st_r.standby_pin_state;
          st_nxt.rdata[CTL_CMP_INPUT_DIS_BIT]     = st_r.cid;
        end
        default: st_nxt.rresp = RESP_SLVERR;
      endcase
    end

    // pin drive, pull-up, interrupt feed and digital input
    st_nxt.pin_out = out_c;
    st_nxt.pin_oe  = oe_c;
    st_nxt.pull_on = st_r.pull & ~(oe_c & ~out_c);
    st_nxt.irq_lvl = st_r.sync2 & ~blk;
    st_nxt.port_in = pin_view;
    st_nxt.cmp_en  = {2{~st_r.cid}};
  end

  // ************************************************************
  // state register
  // ************************************************************
  // reset clears direction and analog-disable; ready flags, write state and comparator enables load set values
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_r         <= '0;
      st_r.latch   <= RST_OUTPUT_LATCH;
      st_r.dir     <= RST_DIRECTION;
      st_r.pull    <= RST_PULLUP_ENABLE;
      st_r.adis    <= RST_ANALOG_DIS;
      st_r.standby_pin_state     <= RST_STANDBY_PIN;
      st_r.cid     <= RST_CMP_INPUT_DIS;
      st_r.wst     <= GP8_W_IDLE;
      st_r.awready <= 1'b1;
      st_r.wready  <= 1'b1;
      st_r.arready <= 1'b1;
      st_r.cmp_en  <= 2'h3;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // every output straight from the state register
  assign O_AWREADY       = st_r.awready;
  assign O_WREADY        = st_r.wready;
  assign O_BRESP         = st_r.bresp;
  assign O_BVALID        = st_r.bvalid;
  assign O_ARREADY       = st_r.arready;
  assign O_RDATA         = st_r.rdata;
  assign O_RRESP         = st_r.rresp;
  assign O_RVALID        = st_r.rvalid;
  assign O_PIN_OUT       = st_r.pin_out;
  assign O_PIN_OE        = st_r.pin_oe;
  assign O_PULLUP_ON     = st_r.pull_on;
  assign O_EXT_IRQ_LEVEL = st_r.irq_lvl;
  assign O_PORT_IN       = st_r.port_in;
  assign O_CMP_IN_EN     = st_r.cmp_en;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);

  // an output pin with no peripheral drives its latch bit unless standby floats the pins
  AST_OUT_DRIVES_LATCH: assert property (
    (st_r.dir[0] && !I_PERIPH_OE[0] && !float_all) |=>
    (O_PIN_OE[0] && O_PIN_OUT[0] == $past(st_r.latch[0])))
    else $error("output pin does not drive latch");

  // an input pin with no peripheral is not driven
  AST_INPUT_NOT_DRIVEN: assert property (
    (!st_r.dir[3] && !I_PERIPH_OE[3]) |=> !O_PIN_OE[3])
    else $error("input pin driven");

  // a latch write lands whatever the direction
  AST_LATCH_WRITE: assert property (
    (st_r.wst == GP8_W_IDLE && st_r.aw_full && st_r.w_full &&
     st_r.w_lane0 && st_r.aw_addr == OFS_OUTPUT_LATCH) |=>
    (st_r.latch == $past(st_r.w_data)))
    else $error("latch write lost");

  // the rmw view always returns the latch one cycle after the address
  AST_RMW_VIEW: assert property (
    (I_ARVALID && st_r.arready && I_ARADDR == OFS_LATCH_RMW) |=>
    (O_RVALID && O_RDATA[7:0] == $past(st_r.latch)))
    else $error("rmw read not latch");

  // normal read of an input pin returns the gated pin level
  AST_NORMAL_INPUT: assert property (
    (I_ARVALID && st_r.arready && I_ARADDR == OFS_OUTPUT_LATCH &&
     !st_r.dir[5] && !st_r.adis[5]) |=> (O_RDATA[5] == 1'b0))
    else $error("analog pin reads digital level");

  // standby with pin state set floats every pin for as long as it lasts
  AST_STANDBY_FLOAT: assert property (
    (I_STANDBY && st_r.standby_pin_state) [*2] |=> (O_PIN_OE == '0))
    else $error("pin driven in floating standby");

  // a pin level reaches the interrupt feed three edges later
  AST_IRQ_FEED: assert property (
    (!I_STANDBY && I_PIN_IN[2]) ##1 (!I_STANDBY) ##1 (!I_STANDBY) |=>
    O_EXT_IRQ_LEVEL[2] == $past(I_PIN_IN[2], 3))
    else $error("interrupt feed out of step with pin");

  // the pull-up is never on while the pin drives low
  AST_PULL_CUT: assert property (
    !(O_PULLUP_ON[4] && O_PIN_OE[4] && !O_PIN_OUT[4]))
    else $error("pull-up on while driving low");

  // comparator enable is the inverse of the disable bit
  AST_CMP_EN: assert property (
    $stable(st_r.cid) |=> (O_CMP_IN_EN == {2{~$past(st_r.cid)}}))
    else $error("comparator enable wrong");

  // a write answer follows within two edges of both halves held
  AST_BRESP_TIME: assert property (
    (st_r.aw_full && st_r.w_full) |-> ##[1:2] O_BVALID)
    else $error("write response late");

  COV_RMW_READ:  cover property (I_ARVALID && O_ARREADY &&
                                 I_ARADDR == OFS_LATCH_RMW);
  COV_STBY_FLT:  cover property (I_STANDBY && st_r.standby_pin_state && |I_EXT_IRQ_EN);
  COV_PERIPH_RD: cover property (I_PERIPH_OE[5] && st_r.dir[5] &&
                                 I_ARVALID && O_ARREADY);
  COV_BAD_ADDR:  cover property (O_RVALID && O_RRESP == RESP_SLVERR);

endmodule

`default_nettype wire

// ### sim/gp8_pins.sv
/*
  Model of the external pins of the eight-bit port: the level on each
  pin from the port drive, an outside driver and the internal pull-up.
  Assumes the bench clock and the port outputs of gp8_port.
*/
`timescale 1ns/1ps
`default_nettype none

module gp8_pins
  import gp8_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic [PORT_W-1:0] i_oe,
  input  wire logic [PORT_W-1:0] i_out,
  input  wire logic [PORT_W-1:0] i_pu,
  input  wire logic [PORT_W-1:0] i_ext_en,
  input  wire logic [PORT_W-1:0] i_ext_val,
  output var  logic [PORT_W-1:0] o_pin
);
  logic [PORT_W-1:0] last_r = 8'h00;

  // ************************************************************
  // pin level
  // ************************************************************
  // port drive wins, then the outside driver, then the pull-up
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (i_oe[i]) o_pin[i] = i_out[i];
      else if (i_ext_en[i]) o_pin[i] = i_ext_val[i];
      else if (i_pu[i]) o_pin[i] = 1'b1;
      else o_pin[i] = ~last_r[i]; // floating line holds no value
    end
  end

  // last level, used to scramble a floating line
  always_ff @(posedge i_clk) last_r <= o_pin;
endmodule

`default_nettype wire

// ### sim/eight_bit_port_with_analog_share_tb.sv
/*
  Self-checking bench for gp8_port: AXI4-Lite register access, pin
  drive, read views, pull-ups, standby and comparator enables.
  Assumes gp8_pkg and the pin model gp8_pins.
*/
`timescale 1ns/1ps
`default_nettype none

module eight_bit_port_with_analog_share_tb
  import gp8_pkg::*;
;
  logic        clk, rstn, awv, wv, bry, arv, rry, stby;
  logic [7:0]  awa, ara, p_oe, p_out, irq_en, ext_en, ext_val, pin;
  logic [31:0] wd, rd;
  logic [3:0]  ws;
  logic [1:0]  rr;
  wire  logic        awr, wr, bv, arr, rv;
  wire  logic [1:0]  brsp, rrsp, cmp;
  wire  logic [31:0] rdat;
  wire  logic [7:0]  pout, poe, pu, irq_lv, pin_dig;
  int          n_fail, checks_done;

  gp8_port dut (.I_CLK(clk), .I_RSTN(rstn), .I_AWADDR(awa),
    .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(ws),
    .I_WVALID(wv), .O_WREADY(wr), .O_BRESP(brsp), .O_BVALID(bv),
    .I_BREADY(bry), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr),
    .O_RDATA(rdat), .O_RRESP(rrsp), .O_RVALID(rv), .I_RREADY(rry),
    .I_PIN_IN(pin), .O_PIN_OUT(pout), .O_PIN_OE(poe), .O_PULLUP_ON(pu),
    .I_PERIPH_OE(p_oe), .I_PERIPH_OUT(p_out), .I_STANDBY(stby),
    .I_EXT_IRQ_EN(irq_en), .O_EXT_IRQ_LEVEL(irq_lv),
    .O_PORT_IN(pin_dig), .O_CMP_IN_EN(cmp));

  gp8_pins pins (.i_clk(clk), .i_oe(poe), .i_out(pout), .i_pu(pu),
    .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin(pin));

  // ************************************************************
  // clock and shared tasks
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one write: address and data offered together, response awaited
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge clk);
    awa <= a; awv <= 1'b1; wd <= d; wv <= 1'b1; bry <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(negedge clk);
      ah = awv & awr; wh = wv & wr; bh = bv & bry; rr = brsp;
      @(posedge clk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
      if (bh) begin
        bry <= 1'b0;
        return;
      end
    end
    n_fail++;
    stop_test();
  endtask

  // one read: data and response captured at the falling edge while the answer is valid
  task automatic axr(input logic [7:0] a);
    logic ah, rh;
    @(posedge clk);
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(negedge clk);
      ah = arv & arr; rh = rv & rry; rd = rdat; rr = rrsp;
      @(posedge clk);
      if (ah) arv <= 1'b0;
      if (rh) begin
        rry <= 1'b0;
        return;
      end
    end
    n_fail++;
    stop_test();
  endtask

  // register read compared with an expected low byte
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    axr(a);
    chk(rd, {24'h0, e});
    chk(rr, RESP_OKAY);
  endtask

  // lets register, drive and the pin synchroniser settle
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    rchk(OFS_DIRECTION, RST_DIRECTION);
    rchk(OFS_ANALOG_DIS, RST_ANALOG_DIS);
    rchk(OFS_LATCH_RMW, RST_OUTPUT_LATCH);
    chk(poe, 8'h00);
    chk(cmp, 2'h3);
  endtask

  // output and input pins with analog input selected, then deselected
  task automatic t_io();
    axw(OFS_OUTPUT_LATCH, 32'h000000a5);
    axw(OFS_DIRECTION, 32'h0000000f);
    settle();
    chk(poe, 8'h0f);
    chk(pout & 8'h0f, 8'h05);
    rchk(OFS_OUTPUT_LATCH, 8'h05);
    chk(pin_dig, 8'h00);
    chk(irq_lv, 8'hf5);
    rchk(OFS_LATCH_RMW, 8'ha5);
    axw(OFS_ANALOG_DIS, 32'h000000ff);
    settle();
    rchk(OFS_OUTPUT_LATCH, 8'hf5);
    chk(pin_dig, 8'hf5);
    rchk(OFS_PIN_STATUS, 8'hf5);
  endtask

  // peripheral drives pin 7 low while pull-ups are set
  task automatic t_periph_pullup();
    p_oe <= 8'h80;
    settle();
    chk(poe, 8'h8f);
    chk(pout, 8'h25);
    rchk(OFS_OUTPUT_LATCH, 8'h75);
    rchk(OFS_LATCH_RMW, 8'ha5);
    axw(OFS_PULLUP_ENABLE, 32'h000000ff);
    settle();
    chk(pu, 8'h75);
    p_oe <= 8'h00;
    settle();
  endtask

  // standby with pins floating, then with levels kept
  task automatic t_standby();
    ext_en <= 8'h00;
    irq_en <= 8'h01;
    stby <= 1'b1;
    axw(OFS_CONTROL, 32'h00000001);
    settle();
    chk(poe, 8'h00);
    chk(pin_dig, 8'h01);
    chk(irq_lv, 8'h01);
    axw(OFS_CONTROL, 32'h00000000);
    settle();
    chk(poe, 8'h0f);
    chk(pin_dig, 8'hf5);
    stby <= 1'b0;
    ext_en <= 8'hff;
  endtask

  // comparator enable and unmapped accesses
  task automatic t_cmp_unmapped();
    axw(OFS_CONTROL, 32'h00000002);
    settle();
    chk(cmp, 2'h0);
    rchk(OFS_CONTROL, 8'h02);
    axw(OFS_CONTROL, 32'h00000000);
    settle();
    chk(cmp, 2'h3);
    // write with byte lane 0 off is answered and changes nothing
    ws <= 4'h0;
    axw(OFS_CONTROL, 32'h00000002);
    chk(rr, RESP_OKAY);
    ws <= 4'hf;
    rchk(OFS_CONTROL, 8'h00);
    chk(cmp, 2'h3);
    axw(8'h40, 32'h000000ff);
    chk(rr, RESP_SLVERR);
    axr(8'h40);
    chk(rr, RESP_SLVERR);
    chk(rd, 32'h0);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    n_fail = 0;
    checks_done = 0;
    rstn = 1'b0;
    {awv, wv, bry, arv, rry, stby} = 6'h00;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h0;
    ws = 4'hf;
    p_oe = 8'h00;
    p_out = 8'h00;
    irq_en = 8'h00;
    ext_en = 8'hff;
    ext_val = 8'hf0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_io();
    t_periph_pullup();
    t_standby();
    t_cmp_unmapped();
    // reset again in mid-run, with registers away from their reset values
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    stop_test();
  end
endmodule

`default_nettype wire
